// ==== logic/drc_record.sv ====
// Extended diagnostic record builder with APB register access and interrupt
//
// The address map and the APB slave port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module drc_record (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [31:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [drc_pkg::NUM_INPUTS-1:0] input_event,
	input wire logic [drc_pkg::NUM_INPUTS-1:0] input_ack,
	input wire logic [3:0] group_error,
	input wire drc_pkg::drc_unit_ev_t [drc_pkg::NUM_UNITS-1:0] unit_ev,
	input wire logic [drc_pkg::NUM_UNITS-1:0] unit_ack,
	output logic irq
);
	import drc_pkg::*;

	// Byte packing below is wired for sixteen inputs in four groups and four units
	generate
		if (REC_BYTES != BASIC_BYTES + 12) begin : g_bad_len
			$error("record length must be sixteen bytes");
		end
		if (NUM_INPUTS != 16) begin : g_bad_inputs
			$error("record packing needs sixteen inputs");
		end
		if (NUM_UNITS != 4) begin : g_bad_units
			$error("record packing needs four units");
		end
	endgenerate

	logic [31:0] ctrl;
	logic [31:0] basic;
	logic [STS_WIDTH-1:0] status;
	logic [STS_WIDTH-1:0] mask;
	logic [NUM_INPUTS-1:0] input_lost;
	logic [NUM_UNITS-1:0] ovf_lost;
	logic [NUM_UNITS-1:0] cmp_lost;
	logic [NUM_UNITS-1:0] gcl_lost;
	logic [NUM_UNITS-1:0] gop_lost;
	logic [NUM_UNITS-1:0] mend_lost;
	logic [NUM_UNITS-1:0] unit_err;
	logic [3:0] grp_err;

	wire drc_mode_t mode = drc_mode_t'(ctrl[CTRL_MODE_BIT]);
	wire is_freq = (mode == DRC_MODE_FREQ);
	wire setup = psel & ~penable;
	// Only the completing access cycle writes or clears anything
	wire access = psel & penable & pready;
	wire wr_en = access & pwrite;
	wire rd_en = access & ~pwrite;
	wire [7:0] addr_lo = paddr[7:0];
	wire addr_hit = (paddr[31:8] == 24'h00_0000) && (addr_lo[1:0] == 2'b00) && (addr_lo <= ADDR_REC3);
	wire wr_ctrl = wr_en & (addr_lo == ADDR_CTRL);
	wire wr_basic = wr_en & (addr_lo == ADDR_BASIC);
	wire wr_status = wr_en & (addr_lo == ADDR_STATUS);
	wire wr_mask = wr_en & (addr_lo == ADDR_MASK);
	// Record read clears the lost flags it reported, plus the unreported gate flags of counters 0..2: prdata still holds that word in the
	// access cycle, so a flag set after the setup edge waits for the next read instead of vanishing
	wire rd_rec2 = rd_en & (addr_lo == ADDR_REC2);
	wire rd_rec3 = rd_en & (addr_lo == ADDR_REC3);
	wire clr_cnt = rd_rec3 & ~is_freq;
	wire clr_meter = rd_rec3 & is_freq;
	wire [NUM_INPUTS-1:0] clr_inputs;
	wire [NUM_UNITS-1:0] clr_ovf;
	wire [NUM_UNITS-1:0] clr_cmp;
	wire [NUM_UNITS-1:0] clr_gcl;
	wire [NUM_UNITS-1:0] clr_gop;
	wire [NUM_UNITS-1:0] clr_mend;
	wire [NUM_UNITS-1:0] ovf_in;
	wire [NUM_UNITS-1:0] cmp_in;
	wire [NUM_UNITS-1:0] gcl_in;
	wire [NUM_UNITS-1:0] gop_in;
	wire [NUM_UNITS-1:0] mend_in;
	wire [NUM_UNITS-1:0] err_in;

	genvar gi;
	generate
		for (gi = 0; gi < NUM_UNITS; gi++) begin : g_unit_split
			// Counter events only count in counter mode, meter events only in frequency mode
			assign ovf_in[gi] = unit_ev[gi].overflow & ~is_freq;
			assign cmp_in[gi] = unit_ev[gi].compare & ~is_freq;
			assign gcl_in[gi] = unit_ev[gi].gate_closed & ~is_freq;
			assign gop_in[gi] = unit_ev[gi].gate_opened & ~is_freq;
			assign mend_in[gi] = unit_ev[gi].meas_end & is_freq;
			assign err_in[gi] = unit_ev[gi].error;
			assign clr_ovf[gi] = clr_cnt & prdata[8*gi+4];
			assign clr_cmp[gi] = clr_cnt & prdata[8*gi+6];
			assign clr_mend[gi] = clr_meter & prdata[8*gi];
			if (gi == NUM_UNITS - 1) begin : g_gate_rep
				assign clr_gcl[gi] = clr_cnt & prdata[8*gi];
				assign clr_gop[gi] = clr_cnt & prdata[8*gi+2];
			end else begin : g_gate_hid
				// Gate flags of the first three counters have no record bit, so a read drops them
				assign clr_gcl[gi] = clr_cnt;
				assign clr_gop[gi] = clr_cnt;
			end
			drc_lost_flag u_ovf (
				.pclk(pclk), .presetn(presetn), .event_in(ovf_in[gi]), .ack(unit_ack[gi]),
				.clear(clr_ovf[gi]), .lost(ovf_lost[gi])
			);
			drc_lost_flag u_cmp (
				.pclk(pclk), .presetn(presetn), .event_in(cmp_in[gi]), .ack(unit_ack[gi]),
				.clear(clr_cmp[gi]), .lost(cmp_lost[gi])
			);
			drc_lost_flag u_gcl (
				.pclk(pclk), .presetn(presetn), .event_in(gcl_in[gi]), .ack(unit_ack[gi]),
				.clear(clr_gcl[gi]), .lost(gcl_lost[gi])
			);
			drc_lost_flag u_gop (
				.pclk(pclk), .presetn(presetn), .event_in(gop_in[gi]), .ack(unit_ack[gi]),
				.clear(clr_gop[gi]), .lost(gop_lost[gi])
			);
			drc_lost_flag u_mend (
				.pclk(pclk), .presetn(presetn), .event_in(mend_in[gi]), .ack(unit_ack[gi]),
				.clear(clr_mend[gi]), .lost(mend_lost[gi])
			);
		end
		for (gi = 0; gi < NUM_INPUTS; gi++) begin : g_input
			// Input i is reported at bit 2*i of the third record word
			assign clr_inputs[gi] = rd_rec2 & prdata[2*gi];
			drc_lost_flag u_in (
				.pclk(pclk), .presetn(presetn), .event_in(input_event[gi]), .ack(input_ack[gi]),
				.clear(clr_inputs[gi]), .lost(input_lost[gi])
			);
		end
	endgenerate

	// Record bytes
	wire [7:0] byte4 = {ctrl[CTRL_MORE_BIT], CH_TYPE_DI};
	wire [7:0] byte5 = DIAG_BITS_PER_CH;
	wire [7:0] byte6 = CHANNEL_COUNT;
	// Upper nibble is counter or meter error depending on mode; one register serves both
	wire [7:0] byte7 = {unit_err, grp_err};
	wire [7:0] in_byte [4];
	wire [7:0] unit_byte [4];
	generate
		for (gi = 0; gi < 4; gi++) begin : g_bytes
			assign in_byte[gi] = {1'b0, input_lost[4*gi+3], 1'b0, input_lost[4*gi+2],
				1'b0, input_lost[4*gi+1], 1'b0, input_lost[4*gi]};
			if (gi < 3) begin : g_cnt
				assign unit_byte[gi] = is_freq ? {7'h00, mend_lost[gi]}
					: {1'b0, cmp_lost[gi], 1'b0, ovf_lost[gi], 4'h0};
			end else begin : g_cnt3
				assign unit_byte[gi] = is_freq ? {7'h00, mend_lost[gi]}
					: {1'b0, cmp_lost[gi], 1'b0, ovf_lost[gi],
					1'b0, gop_lost[gi], 1'b0, gcl_lost[gi]};
			end
		end
	endgenerate
	// Sixteen bytes: basic record then twelve module bytes
	wire [31:0] rec0 = basic;
	wire [31:0] rec1 = {byte7, byte6, byte5, byte4};
	wire [31:0] rec2 = {in_byte[3], in_byte[2], in_byte[1], in_byte[0]};
	wire [31:0] rec3 = {unit_byte[3], unit_byte[2], unit_byte[1], unit_byte[0]};

	wire [STS_WIDTH-1:0] ev_now;
	assign ev_now[STS_INPUT_LOST] = |input_event;
	assign ev_now[STS_UNIT_LOST] = |(ovf_in | cmp_in | gcl_in | gop_in | mend_in);
	assign ev_now[STS_GROUP_ERR] = |group_error;
	assign ev_now[STS_UNIT_ERR] = |err_in;
	wire [STS_WIDTH-1:0] clr_bits = wr_status ? pwdata[STS_WIDTH-1:0] : {STS_WIDTH{1'b0}};
	wire [STS_WIDTH-1:0] next_status = ev_now | (status & ~clr_bits);
	wire next_irq = |(next_status & (wr_mask ? pwdata[STS_WIDTH-1:0] : mask));

	logic [31:0] rd_mux;
	always_comb begin
		case (addr_lo)
			ADDR_CTRL: rd_mux = ctrl;
			ADDR_BASIC: rd_mux = basic;
			ADDR_STATUS: rd_mux = {28'h000_0000, status};
			ADDR_MASK: rd_mux = {28'h000_0000, mask};
			ADDR_REC0: rd_mux = rec0;
			ADDR_REC1: rd_mux = rec1;
			ADDR_REC2: rd_mux = rec2;
			ADDR_REC3: rd_mux = rec3;
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl <= CTRL_RESET;
		end else if (wr_ctrl) begin
			ctrl <= {30'h0000_0000, pwdata[CTRL_MORE_BIT], pwdata[CTRL_MODE_BIT]};
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			basic <= BASIC_RESET;
		end else if (wr_basic) begin
			basic <= pwdata;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mask <= MASK_RESET;
		end else if (wr_mask) begin
			mask <= pwdata[STS_WIDTH-1:0];
		end
	end

	// Group and unit error bits follow the live error levels
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			grp_err <= 4'h0;
		end else begin
			grp_err <= group_error;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			unit_err <= 4'h0;
		end else begin
			unit_err <= err_in;
		end
	end

	// A clear write loses to an event in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status <= {STS_WIDTH{1'b0}};
		end else begin
			status <= next_status;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq <= 1'b0;
		end else begin
			irq <= next_irq;
		end
	end

	// Answer one cycle after setup: pready rises in the access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
		end else begin
			pready <= setup;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pslverr <= 1'b0;
		end else begin
			pslverr <= setup & ~addr_hit;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else begin
			prdata <= (setup & ~pwrite) ? rd_mux : 32'h0000_0000;
		end
	end
endmodule
`default_nettype wire

// ==== logic/drc_pkg.sv ====
// Constants, register map and carrier types of the extended diagnostic record builder
// How it works
// - Record is four basic bytes then twelve module bytes, sixteen total.
// - Byte 4 bits 6..0 carry channel type code, 70h for digital input.
// - Byte 4 bit 7 flags that further channel types follow.
// - Byte 5 holds eight diagnostic bits per channel.
// - Byte 6 holds eight channels per module.
// - Byte 7 bits 0..3 flag errors in four-input channel groups.
// - Frequency mode: byte 7 bits 4..7 flag errors of meters 0..3.
// - Counter mode bytes 12..14: bit4 overflow lost, bit6 compare lost, rest zero.
// - Counter mode byte 15: bit0 gate closed, bit2 gate opened, bit1 zero.
// - Counter mode byte 15: bit4 overflow lost, bit6 compare lost, bits5,7 zero.
// - Frequency mode bytes 12..15: bit0 end of measurement lost, others zero.
// - Counter mode: byte 7 bits 4..7 flag errors of counters 0..3.
package drc_pkg;
	localparam int REC_BYTES = 16;
	localparam int BASIC_BYTES = 4;
	localparam logic [6:0] CH_TYPE_DI = 7'h70;
	localparam logic [6:0] CH_TYPE_AI = 7'h71;
	localparam logic [6:0] CH_TYPE_DO = 7'h72;
	localparam logic [6:0] CH_TYPE_AO = 7'h73;
	localparam logic [6:0] CH_TYPE_AIO = 7'h74;
	localparam logic [7:0] DIAG_BITS_PER_CH = 8'h08;
	localparam logic [7:0] CHANNEL_COUNT = 8'h08;
	localparam int NUM_INPUTS = 16;
	localparam int NUM_UNITS = 4;
	// Register byte addresses
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_BASIC = 8'h04;
	localparam logic [7:0] ADDR_STATUS = 8'h08;
	localparam logic [7:0] ADDR_MASK = 8'h0C;
	localparam logic [7:0] ADDR_REC0 = 8'h10;
	localparam logic [7:0] ADDR_REC1 = 8'h14;
	localparam logic [7:0] ADDR_REC2 = 8'h18;
	localparam logic [7:0] ADDR_REC3 = 8'h1C;
	// Control fields
	localparam int CTRL_MODE_BIT = 0;
	localparam int CTRL_MORE_BIT = 1;
	// Status fields
	localparam int STS_INPUT_LOST = 0;
	localparam int STS_UNIT_LOST = 1;
	localparam int STS_GROUP_ERR = 2;
	localparam int STS_UNIT_ERR = 3;
	localparam int STS_WIDTH = 4;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam logic [31:0] BASIC_RESET = 32'h0000_0000;
	localparam logic [STS_WIDTH-1:0] MASK_RESET = 4'h0;
	typedef enum logic {DRC_MODE_COUNTER = 1'b0, DRC_MODE_FREQ = 1'b1} drc_mode_t;
	// Per-unit event strobes plus error level, counter or frequency meter
	typedef struct packed {
		logic overflow;
		logic compare;
		logic gate_closed;
		logic gate_opened;
		logic meas_end;
		logic error;
	} drc_unit_ev_t;
	typedef struct packed {
		logic [31:0] paddr;
		logic psel;
		logic penable;
		logic pwrite;
		logic [31:0] pwdata;
	} drc_apb_req_t;
endpackage

// ==== logic/drc_lost_flag.sv ====
// One sticky lost-interrupt flag: a second event while pending is recorded
`timescale 1ns/1ps
`default_nettype none
module drc_lost_flag (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic event_in,
	input wire logic ack,
	input wire logic clear,
	output logic lost
);
	logic pending;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pending <= 1'b0;
		end else begin
			pending <= event_in | (pending & ~ack);
		end
	end
	// Set wins over clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lost <= 1'b0;
		end else begin
			lost <= (event_in & pending & ~ack) | (lost & ~clear);
		end
	end
endmodule
`default_nettype wire

// ==== tb/drc_record_monitor.sv ====
// Concurrent checks on the record builder's bus answers and record words
`timescale 1ns/1ps
`default_nettype none
module drc_record_monitor
import drc_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [31:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic irq
);
	logic [1:0] ctrl_m;
	logic rd_ok;
	assign rd_ok = pready && !pwrite && !pslverr;
	// Shadow of mode and more-types, taken from completed writes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_m <= 2'h0;
		end else if (psel && penable && pready && pwrite && paddr == ADDR_CTRL) begin
			ctrl_m <= pwdata[1:0];
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	chk_ready_one: assert property (pready |=> !pready) else $error("pready held");
	chk_ready_setup: assert property (pready |-> $past(psel && !penable)) else $error("pready without setup");
	chk_err_ready: assert property (pslverr |-> pready) else $error("pslverr alone");
	chk_type_code: assert property (rd_ok && paddr == ADDR_REC1 |-> prdata[6:0] == CH_TYPE_DI)
		else $error("bad type code");
	chk_more_bit: assert property (rd_ok && paddr == ADDR_REC1 |-> prdata[7] == ctrl_m[1])
		else $error("bad more bit");
	chk_count_bytes: assert property (rd_ok && paddr == ADDR_REC1 |-> prdata[23:8] == {CHANNEL_COUNT, DIAG_BITS_PER_CH})
		else $error("bad counts");
	chk_odd_zero: assert property (rd_ok && paddr == ADDR_REC2 |-> (prdata & 32'hAAAA_AAAA) == 32'h0)
		else $error("odd lost bit set");
	chk_cnt_zero: assert property (rd_ok && paddr == ADDR_REC3 && !ctrl_m[0] |-> (prdata & 32'hA2AF_AFAF) == 32'h0)
		else $error("counter fixed bit set");
	chk_freq_zero: assert property (rd_ok && paddr == ADDR_REC3 && ctrl_m[0] |-> (prdata & 32'hFEFE_FEFE) == 32'h0)
		else $error("meter fixed bit set");
	cover property (rd_ok && paddr == ADDR_REC3 && ctrl_m[0]);
	cover property (rd_ok && paddr == ADDR_REC2 && prdata != 32'h0);
	cover property (irq);
endmodule
bind drc_record drc_record_monitor u_mon (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
	.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .irq(irq));
`default_nettype wire

// ==== tb/drc_src.sv ====
// Process-side event source: interrupt pulses, unit errors and acknowledges
`timescale 1ns/1ps
`default_nettype none
module drc_src (
	input wire logic pclk,
	output var logic [drc_pkg::NUM_INPUTS-1:0] input_event,
	output var logic [drc_pkg::NUM_INPUTS-1:0] input_ack,
	output var drc_pkg::drc_unit_ev_t [drc_pkg::NUM_UNITS-1:0] unit_ev,
	output var logic [drc_pkg::NUM_UNITS-1:0] unit_ack
);
	import drc_pkg::*;
	initial begin
		input_event = '0;
		input_ack = '0;
		unit_ev = '0;
		unit_ack = '0;
	end
	task automatic fire_in(input int i);
		@(posedge pclk) input_event[i] <= 1'b1;
		@(posedge pclk) input_event[i] <= 1'b0;
	endtask
	// Error is a level, so pulses leave it alone
	task automatic fire_u(input int u, input drc_unit_ev_t ev);
		@(posedge pclk) unit_ev[u][5:1] <= ev[5:1];
		@(posedge pclk) unit_ev[u][5:1] <= 5'h00;
	endtask
	task automatic set_err(input int u, input logic v);
		@(posedge pclk) unit_ev[u].error <= v;
	endtask
	task automatic ack_all();
		@(posedge pclk) begin
			input_ack <= '1;
			unit_ack <= '1;
		end
		@(posedge pclk) begin
			input_ack <= '0;
			unit_ack <= '0;
		end
	endtask
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
// Register-level tests of the extended diagnostic record builder
`timescale 1ns/1ps
`default_nettype none
module tb;
	import drc_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
	logic [31:0] paddr, pwdata, prdata;
	logic [3:0] group_error;
	logic [15:0] ie, ia;
	logic [3:0] ua;
	drc_unit_ev_t [3:0] uev;
	int fail_count = 0;
	int check_count = 0;
	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end
	drc_record u_drc_record (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .input_event(ie), .input_ack(ia), .group_error(group_error),
		.unit_ev(uev), .unit_ack(ua), .irq(irq));
	drc_src u_drc_src (.pclk(pclk), .input_event(ie), .input_ack(ia), .unit_ev(uev), .unit_ack(ua));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// One transfer; waits for pready, no fixed latency assumed
	task automatic apb(input logic [31:0] a, input logic w, input logic [31:0] d, input logic [31:0] exp,
		input logic err);
		@(posedge pclk) begin
			paddr <= a;
			pwrite <= w;
			pwdata <= d;
			psel <= 1'b1;
		end
		@(posedge pclk) penable <= 1'b1;
		// pready ends this wait; if it never comes, only the watchdog does
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		if (!w) chk(prdata, exp);
		chk({31'h0, pslverr}, {31'h0, err});
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		apb(a, 1'b1, d, 32'h0, 1'b0);
	endtask
	task automatic rd(input logic [31:0] a, input logic [31:0] exp);
		apb(a, 1'b0, 32'h0, exp, 1'b0);
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	initial begin
		{psel, penable, pwrite, paddr, pwdata, group_error} = '0;
		presetn = 1'b0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		rd(ADDR_CTRL, CTRL_RESET);
		rd(ADDR_MASK, 32'h0);
		rd(ADDR_REC1, 32'h0008_0870);
		apb(32'h40, 1'b0, 32'h0, 32'h0, 1'b1);
		$display("reset and map done");
		wr(ADDR_BASIC, 32'hA5C3_1E07);
		rd(ADDR_REC0, 32'hA5C3_1E07);
		wr(ADDR_CTRL, 32'h2);
		group_error <= 4'h5;
		u_drc_src.set_err(2, 1'b1);
		rd(ADDR_REC1, 32'h4508_08F0);
		group_error <= 4'hA;
		u_drc_src.set_err(2, 1'b0);
		u_drc_src.set_err(3, 1'b1);
		wr(ADDR_CTRL, 32'h1);
		rd(ADDR_REC1, 32'h8A08_0870);
		u_drc_src.set_err(3, 1'b0);
		group_error <= 4'h0;
		wr(ADDR_CTRL, 32'h0);
		$display("header bytes done");
		repeat (2) u_drc_src.fire_in(0);
		repeat (2) u_drc_src.fire_in(15);
		rd(ADDR_REC2, 32'h4000_0001);
		rd(ADDR_REC2, 32'h0);
		chk({31'h0, irq}, 32'h0);
		wr(ADDR_MASK, 32'h1);
		@(posedge pclk);
		#1 chk({31'h0, irq}, 32'h1);
		wr(ADDR_STATUS, 32'h1);
		@(posedge pclk);
		#1 chk({31'h0, irq}, 32'h0);
		rd(ADDR_STATUS, 32'hC);
		wr(ADDR_STATUS, 32'hC);
		rd(ADDR_STATUS, 32'h0);
		$display("input lost and irq done");
		u_drc_src.ack_all();
		repeat (2) u_drc_src.fire_u(0, 6'h20);
		repeat (2) u_drc_src.fire_u(3, 6'h1C);
		rd(ADDR_REC3, 32'h4500_0010);
		rd(ADDR_REC3, 32'h0);
		u_drc_src.ack_all();
		wr(ADDR_CTRL, 32'h1);
		for (int u = 0; u < 4; u++) repeat (2) u_drc_src.fire_u(u, 6'h02);
		rd(ADDR_REC3, 32'h0101_0101);
		$display("unit lost done");
		tally_and_finish();
	end
	initial begin
		#200us;
		fail_count++;
		$display("[FAIL] %0t watchdog expired", $time);
		tally_and_finish();
	end
endmodule
`default_nettype wire
